// File: verilog/esmp_mem_port.sv
// edo dram / sdram external memory port: strobes, address, data, clock
`timescale 1ns/1ns
`include "esmp_map.svh"

// Functional notes
// - in edo mode the low bank selects are row strobes latching the row.
// - in edo mode each row strobe selects exactly one of two banks.
// - in sdram mode the same outputs are chip selects gating the decoder.
// - in sdram mode with a dimm fitted, high-word selects mark upper 32-bit accesses.
// - each sdram command is the level set of row, column, write, select.
// - the write strobe is low on every write cycle and high on reads.
// - in edo mode the four lane strobes latch the column address.
// - in edo mode only the lanes to be accessed get a column strobe.
// - in sdram mode lanes are write data masks and read output enables.
// - row and column addresses share one fourteen-line address bus.
// - the port drives the 32-line data bus on writes, memory on reads.
// - a clock-enable output gates the memory clock inside the sdram.
// - the memory clock is output and memory signals refer to its rise.
module esmp_mem_port (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RSTN,
   // configuration
   input wire logic MODE_SDRAM,
   input wire logic DIMM_FITTED,
   input wire logic CLK_SUSPEND,
   // access request
   input wire logic REQ_VALID,
   input wire logic REQ_WRITE,
   input wire logic REQ_BANK,
   input wire logic REQ_HIGH_WORD,
   input wire logic [`ESMP_ADDR_W-1:0] REQ_ROW,
   input wire logic [`ESMP_COL_W-1:0] REQ_COL,
   input wire logic [`ESMP_LANES-1:0] REQ_BYTE_EN,
   input wire logic [`ESMP_DATA_W-1:0] REQ_WDATA,
   output logic REQ_READY,
   // read answer
   output logic RSP_VALID,
   output logic [`ESMP_DATA_W-1:0] RSP_RDATA,
   // memory clock
   output logic MEM_CLK,
   output logic MEM_CKE,
   // selects and strobes
   output logic BANK0_SELECT_LOW_N,
   output logic BANK1_SELECT_LOW_N,
   output logic BANK0_SELECT_HIGH_WORD_N,
   output logic BANK1_SELECT_HIGH_WORD_N,
   output logic ROW_STROBE_N,
   output logic COL_STROBE_N,
   output logic WRITE_STROBE_N,
   output logic [`ESMP_LANES-1:0] BYTE_LANE_STROBE_MASK,
   // address and data
   output logic [`ESMP_ADDR_W-1:0] MEM_ADDR_MUX,
   input wire logic [`ESMP_DATA_W-1:0] MEM_DATA_BUS_I,
   output logic [`ESMP_DATA_W-1:0] MEM_DATA_BUS_O,
   output logic MEM_DATA_BUS_OE
);

   // ****************************************************************
   // helper functions
   // ****************************************************************

   // active-high select vector for one bank and word half
   function automatic logic [`ESMP_SEL_W-1:0] sel_vec(
      input logic sdram, input logic bank,
      input logic high, input logic dimm
   );
      logic [`ESMP_SEL_W-1:0] v;
      v = '0;
      if (sdram && dimm && high) begin
         v[bank ? `ESMP_SEL_B1_HIGH : `ESMP_SEL_B0_HIGH] = 1'b1;
      end else begin
         v[bank ? `ESMP_SEL_B1_LOW : `ESMP_SEL_B0_LOW] = 1'b1;
      end
      return v;
   endfunction

   // row phase address; edo parts only decode the low twelve lines
   function automatic logic [`ESMP_ADDR_W-1:0] row_addr(
      input logic sdram,
      input logic [`ESMP_ADDR_W-1:0] row
   );
      logic [`ESMP_ADDR_W-1:0] a;
      a = sdram ? row : {2'h0, row[`ESMP_EDO_ROW_W-1:0]};
      return a;
   endfunction

   // column phase address; sdram moves bit 10 up for auto precharge
   function automatic logic [`ESMP_ADDR_W-1:0] col_addr(
      input logic sdram,
      input logic [`ESMP_COL_W-1:0] col
   );
      logic [`ESMP_ADDR_W-1:0] a;
      a = sdram ? {2'h0, col[`ESMP_AP_BIT], 1'b1, col[`ESMP_AP_BIT-1:0]}
         : {2'h0, col};
      return a;
   endfunction

   // ****************************************************************
   // memory clock divider
   // ****************************************************************
   logic [`ESMP_PHASE_W-1:0] phase_ff, nxt_phase;
   logic mclk_ff, nxt_mclk, tick;

   // high for the first half period; rising edge at phase zero
   always_comb begin
      nxt_phase = phase_ff + 3'h1;
      nxt_mclk = (nxt_phase < `ESMP_PHASE_W'(`ESMP_MEM_CLK_HALF));
   end

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         phase_ff <= `ESMP_RST_PHASE; // wraps first, so no short high half
         mclk_ff <= 1'b0;
      end else begin
         phase_ff <= nxt_phase;
         mclk_ff <= nxt_mclk;
      end
   end

   // launch on the falling edge so signals settle before the next rise
   assign tick = (phase_ff == `ESMP_PHASE_W'(`ESMP_LAUNCH_PHASE));

   // ****************************************************************
   // read data pins into the core clock domain
   // ****************************************************************
   logic [`ESMP_DATA_W-1:0] din_sync;

   esmp_sync2 #(.WIDTH(`ESMP_DATA_W)) u_din_sync (.clk(CORE_CLK),
      .rst_n(RSTN), .async_in(MEM_DATA_BUS_I), .sync_out(din_sync));

   // ****************************************************************
   // access sequencer
   // ****************************************************************
   esmp_pkg::esmp_state_e state_ff;
   esmp_pkg::esmp_state_e nxt_state;
   logic sdram_ff, nxt_sdram;
   logic wr_ff, nxt_wr;
   logic [`ESMP_SEL_W-1:0] selv_ff, nxt_selv;
   logic [`ESMP_ADDR_W-1:0] row_ff, nxt_row;
   logic [`ESMP_COL_W-1:0] col_ff, nxt_col;
   logic [`ESMP_LANES-1:0] be_ff, nxt_be;
   logic [`ESMP_CNT_W-1:0] cnt_ff, nxt_cnt;
   logic cke_ff, nxt_cke;
   logic [`ESMP_SEL_W-1:0] sel_n_ff, nxt_sel_n;
   logic [2:0] cmd_ff, nxt_cmd;
   logic [`ESMP_LANES-1:0] lane_ff, nxt_lane;
   logic [`ESMP_ADDR_W-1:0] addr_ff, nxt_addr;
   logic [`ESMP_DATA_W-1:0] dout_ff, nxt_dout;
   logic oe_ff, nxt_oe;
   logic ready_ff, nxt_ready;
   logic rsp_valid_ff, nxt_rsp_valid;
   logic [`ESMP_DATA_W-1:0] rdata_ff, nxt_rdata;
   logic take;
   assign take = REQ_VALID && ready_ff;

   // next values of the whole sequencer; strobes, selects, address and enables only move on a tick
   always_comb begin
      nxt_state = state_ff;
      nxt_sdram = sdram_ff;
      nxt_wr = wr_ff;
      nxt_selv = selv_ff;
      nxt_row = row_ff;
      nxt_col = col_ff;
      nxt_be = be_ff;
      nxt_cnt = cnt_ff;
      nxt_cke = cke_ff;
      nxt_sel_n = sel_n_ff;
      nxt_cmd = cmd_ff;
      nxt_lane = lane_ff;
      nxt_addr = addr_ff;
      nxt_dout = dout_ff;
      nxt_oe = oe_ff;
      nxt_ready = ready_ff;
      nxt_rsp_valid = 1'b0;
      nxt_rdata = rdata_ff;
      // clock enable only drops while idle, never inside an access
      if (tick) begin
         nxt_cke = !(CLK_SUSPEND &&
            state_ff == esmp_pkg::ST_IDLE);
      end
      case (state_ff)
         esmp_pkg::ST_IDLE: begin
            nxt_ready = 1'b1; // idle always offers; a take withdraws it
            if (take) begin
               // mode is latched per access so a change never splits one
               nxt_sdram = MODE_SDRAM;
               nxt_wr = REQ_WRITE;
               nxt_selv = sel_vec(MODE_SDRAM, REQ_BANK, REQ_HIGH_WORD,
                  DIMM_FITTED);
               nxt_row = REQ_ROW;
               nxt_col = REQ_COL;
               nxt_be = REQ_BYTE_EN;
               nxt_dout = REQ_WDATA;
               nxt_ready = 1'b0;
               nxt_state = esmp_pkg::ST_PEND;
            end
         end
         esmp_pkg::ST_PEND: begin
            // row phase: edo row strobe or sdram activate
            if (tick && cke_ff) begin
               nxt_sel_n = ~selv_ff;
               nxt_addr = row_addr(sdram_ff, row_ff);
               nxt_cmd = sdram_ff ? esmp_pkg::CMD_ACTIVE
                  : esmp_pkg::CMD_NOP;
               nxt_state = esmp_pkg::ST_ROW;
            end
         end
         esmp_pkg::ST_ROW: begin
            // column phase with data, lanes and write strobe
            if (tick) begin
               nxt_addr = col_addr(sdram_ff, col_ff);
               nxt_oe = wr_ff;
               nxt_cnt = sdram_ff ? `ESMP_CNT_W'(`ESMP_CAS_LATENCY)
                  : `ESMP_CNT_W'(`ESMP_EDO_LATENCY);
               if (sdram_ff) begin
                  nxt_cmd = wr_ff ? esmp_pkg::CMD_WRITE
                     : esmp_pkg::CMD_READ;
                  nxt_lane = ~be_ff;
               end else begin
                  // rows stay strobed, lanes strobe the column
                  nxt_cmd = wr_ff ? 3'h6 : esmp_pkg::CMD_NOP;
                  nxt_lane = ~be_ff;
               end
               nxt_state = esmp_pkg::ST_COL;
            end
         end
         esmp_pkg::ST_COL: begin
            if (tick) begin
               // sdram commands last one memory clock, then deselect
               if (sdram_ff) begin
                  nxt_sel_n = `ESMP_RST_SEL_N;
                  nxt_cmd = esmp_pkg::CMD_NOP;
                  if (wr_ff) begin
                     nxt_lane = `ESMP_RST_LANES;
                  end
               end
               nxt_oe = 1'b0;
               if (cnt_ff == `ESMP_CNT_W'(1)) begin
                  // synced copy holds what the pins showed at the rise
                  if (!wr_ff) begin
                     nxt_rdata = din_sync;
                     nxt_rsp_valid = 1'b1;
                  end
                  nxt_sel_n = `ESMP_RST_SEL_N;
                  nxt_cmd = esmp_pkg::CMD_NOP;
                  nxt_lane = `ESMP_RST_LANES;
                  nxt_state = esmp_pkg::ST_REST;
               end else begin
                  nxt_cnt = cnt_ff - `ESMP_CNT_W'(1);
               end
            end
         end
         esmp_pkg::ST_REST: begin
            // one memory clock of precharge before the next access
            if (tick) begin
               nxt_ready = 1'b1;
               nxt_state = esmp_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_sel_n = `ESMP_RST_SEL_N;
            nxt_cmd = esmp_pkg::CMD_NOP;
            nxt_lane = `ESMP_RST_LANES;
            nxt_oe = 1'b0;
            nxt_ready = 1'b1;
            nxt_state = esmp_pkg::ST_IDLE;
         end
      endcase
   end

   // strobes come out of reset deasserted
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         state_ff <= esmp_pkg::ST_IDLE;
         sdram_ff <= 1'b0;
         wr_ff <= 1'b0;
         selv_ff <= '0;
         row_ff <= '0;
         col_ff <= '0;
         be_ff <= '0;
         cnt_ff <= '0;
         cke_ff <= 1'b0;
         sel_n_ff <= `ESMP_RST_SEL_N;
         cmd_ff <= esmp_pkg::CMD_NOP;
         lane_ff <= `ESMP_RST_LANES;
         addr_ff <= '0;
         dout_ff <= '0;
         oe_ff <= 1'b0;
         ready_ff <= 1'b0;
         rsp_valid_ff <= 1'b0;
         rdata_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         sdram_ff <= nxt_sdram;
         wr_ff <= nxt_wr;
         selv_ff <= nxt_selv;
         row_ff <= nxt_row;
         col_ff <= nxt_col;
         be_ff <= nxt_be;
         cnt_ff <= nxt_cnt;
         cke_ff <= nxt_cke;
         sel_n_ff <= nxt_sel_n;
         cmd_ff <= nxt_cmd;
         lane_ff <= nxt_lane;
         addr_ff <= nxt_addr;
         dout_ff <= nxt_dout;
         oe_ff <= nxt_oe;
         ready_ff <= nxt_ready;
         rsp_valid_ff <= nxt_rsp_valid;
         rdata_ff <= nxt_rdata;
      end
   end

   // ****************************************************************
   // outputs, each straight from a flip-flop
   // ****************************************************************
   assign REQ_READY = ready_ff;
   assign RSP_VALID = rsp_valid_ff;
   assign RSP_RDATA = rdata_ff;
   assign MEM_CLK = mclk_ff;
   assign MEM_CKE = cke_ff;
   assign BANK0_SELECT_LOW_N = sel_n_ff[`ESMP_SEL_B0_LOW];
   assign BANK1_SELECT_LOW_N = sel_n_ff[`ESMP_SEL_B1_LOW];
   assign BANK0_SELECT_HIGH_WORD_N = sel_n_ff[`ESMP_SEL_B0_HIGH];
   assign BANK1_SELECT_HIGH_WORD_N = sel_n_ff[`ESMP_SEL_B1_HIGH];
   assign ROW_STROBE_N = cmd_ff[2];
   assign COL_STROBE_N = cmd_ff[1];
   assign WRITE_STROBE_N = cmd_ff[0];
   assign BYTE_LANE_STROBE_MASK = lane_ff;
   assign MEM_ADDR_MUX = addr_ff;
   assign MEM_DATA_BUS_O = dout_ff;
   assign MEM_DATA_BUS_OE = oe_ff;

endmodule

// File: verilog/esmp_map.svh
// constants of the edo / sdram memory port: widths, timing, address layout
`ifndef ESMP_MAP_SVH
`define ESMP_MAP_SVH

// ****************************************************************
// bus widths
// ****************************************************************
`define ESMP_ADDR_W 14
`define ESMP_DATA_W 32
`define ESMP_LANES 4
`define ESMP_COL_W 12
`define ESMP_EDO_ROW_W 12
`define ESMP_SEL_W 4

// ****************************************************************
// select vector bit positions
// ****************************************************************
`define ESMP_SEL_B0_LOW 0
`define ESMP_SEL_B1_LOW 1
`define ESMP_SEL_B0_HIGH 2
`define ESMP_SEL_B1_HIGH 3

// ****************************************************************
// sdram column phase: auto precharge address bit
// ****************************************************************
`define ESMP_AP_BIT 10

// ****************************************************************
// timing
// ****************************************************************
`define ESMP_CORE_CLK_NS 100
`define ESMP_MEM_CLK_NS 800
`define ESMP_MEM_CLK_DIV (`ESMP_MEM_CLK_NS / `ESMP_CORE_CLK_NS)
`define ESMP_MEM_CLK_HALF (`ESMP_MEM_CLK_DIV / 2)
`define ESMP_PHASE_W 3
`define ESMP_LAUNCH_PHASE (`ESMP_MEM_CLK_HALF - 1)
`define ESMP_CAS_LATENCY 2
`define ESMP_EDO_LATENCY 1
`define ESMP_CNT_W 2

// ****************************************************************
// reset values
// ****************************************************************
`define ESMP_RST_SEL_N 4'hf
`define ESMP_RST_LANES 4'hf
`define ESMP_RST_PHASE 3'h7

`endif

// File: verilog/esmp_pkg.sv
// types of the edo / sdram memory port
package esmp_pkg;

   // ****************************************************************
   // access sequencer states, one-hot
   // ****************************************************************
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_PEND = 5'h02,
      ST_ROW  = 5'h04,
      ST_COL  = 5'h08,
      ST_REST = 5'h10
   } esmp_state_e;

   // ****************************************************************
   // sdram command as {row strobe, column strobe, write strobe}
   // ****************************************************************
   typedef enum logic [2:0] {
      CMD_NOP    = 3'h7,
      CMD_ACTIVE = 3'h3,
      CMD_READ   = 3'h5,
      CMD_WRITE  = 3'h4
   } esmp_cmd_e;

endpackage

// File: verilog/esmp_sync2.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns

module esmp_sync2 #(
   parameter int WIDTH = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // asynchronous input and its synchronised copy
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;

endmodule

// File: testbench/esmp_mem_port_checker.sv
// pin-level assertion checker for the edo / sdram memory port
`timescale 1ns/1ns

module esmp_mem_port_checker (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RSTN,
   // configuration
   input wire logic MODE_SDRAM,
   input wire logic DIMM_FITTED,
   // read answer
   input wire logic RSP_VALID,
   // memory pins
   input wire logic MEM_CLK,
   input wire logic MEM_CKE,
   input wire logic BANK0_SELECT_LOW_N,
   input wire logic BANK1_SELECT_LOW_N,
   input wire logic BANK0_SELECT_HIGH_WORD_N,
   input wire logic BANK1_SELECT_HIGH_WORD_N,
   input wire logic ROW_STROBE_N,
   input wire logic COL_STROBE_N,
   input wire logic WRITE_STROBE_N,
   input wire logic [3:0] BYTE_LANE_STROBE_MASK,
   input wire logic [13:0] MEM_ADDR_MUX,
   input wire logic MEM_DATA_BUS_OE
);
   // ****
   // helpers
   // ****
   logic [3:0] sel_n;
   logic [2:0] cmd;
   assign sel_n = {BANK1_SELECT_HIGH_WORD_N, BANK0_SELECT_HIGH_WORD_N,
      BANK1_SELECT_LOW_N, BANK0_SELECT_LOW_N};
   assign cmd = {ROW_STROBE_N, COL_STROBE_N, WRITE_STROBE_N};

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RSTN);

   // ****
   // assertions
   // ****
   a_one_select: assert property ($countones(~sel_n) <= 1)
      else $error("more than one select low");
   a_edo_shared_idle: assert property (!MODE_SDRAM |->
      cmd[2:1] == 2'h3)
      else $error("row or column strobe used in edo mode");
   a_sdram_cmd_sel: assert property (MODE_SDRAM |->
      ((sel_n != 4'hf) == (cmd != esmp_pkg::CMD_NOP)))
      else $error("command and chip select disagree");
   a_high_needs_dimm: assert property ((sel_n[3:2] != 2'h3) |->
      MODE_SDRAM && DIMM_FITTED)
      else $error("high word select without dimm");
   a_write_drives: assert property (
      MEM_DATA_BUS_OE == !WRITE_STROBE_N)
      else $error("data drive and write strobe disagree");
   // pins only move at the falling memory clock, half a period before sampling
   a_tick_only: assert property ($changed({sel_n, cmd,
      BYTE_LANE_STROBE_MASK, MEM_ADDR_MUX}) |-> $fell(MEM_CLK))
      else $error("memory pins moved off the falling clock");
   a_clk_shape: assert property ($rose(MEM_CLK) |-> MEM_CLK[*4] ##1
      !MEM_CLK[*4] ##1 MEM_CLK)
      else $error("memory clock not four high four low");
   a_cke_active: assert property (((sel_n != 4'hf) ||
      (BYTE_LANE_STROBE_MASK != 4'hf)) |-> MEM_CKE)
      else $error("memory activity with clock disabled");
   a_cas_in_row: assert property ((!MODE_SDRAM &&
      BYTE_LANE_STROBE_MASK != 4'hf) |-> sel_n[1:0] != 2'h3)
      else $error("column strobe without row strobe");
   a_rsp_pulse: assert property (RSP_VALID |=> !RSP_VALID)
      else $error("read answer longer than one cycle");
endmodule

bind esmp_mem_port esmp_mem_port_checker u_chk (
   .CORE_CLK, .RSTN, .MODE_SDRAM, .DIMM_FITTED, .RSP_VALID, .MEM_CLK,
   .MEM_CKE, .BANK0_SELECT_LOW_N, .BANK1_SELECT_LOW_N,
   .BANK0_SELECT_HIGH_WORD_N, .BANK1_SELECT_HIGH_WORD_N, .ROW_STROBE_N,
   .COL_STROBE_N, .WRITE_STROBE_N, .BYTE_LANE_STROBE_MASK, .MEM_ADDR_MUX,
   .MEM_DATA_BUS_OE
);

// File: testbench/esmp_tb_mem_model.sv
// behavioural edo / sdram memory on the far side of the port
`timescale 1ns/1ns
`include "esmp_map.svh"

module esmp_tb_mem_model (
   // memory clock and mode
   input wire logic mem_clk,
   input wire logic mem_cke,
   input wire logic mode_sdram,
   // selects and strobes, active low
   input wire logic [3:0] sel_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [3:0] lane_n,
   // address and data
   input wire logic [13:0] addr,
   input wire logic [31:0] dq_in,
   output logic [31:0] dq_out
);
   logic [31:0] mem [bit [30:0]];
   logic [13:0] row_q = 14'h0;
   logic bank_q = 1'b0;
   logic hw_q = 1'b0;
   int rd_wait = 0;
   bit [30:0] rd_key;
   bit [30:0] k;
   logic [3:0] rd_lanes;
   logic [31:0] word;

   initial dq_out = 32'h5a5a5a5a;

   function automatic logic [31:0] merge(input logic [31:0] a,
      input logic [31:0] b, input logic [3:0] en);
      for (int i = 0; i < 4; i++) begin
         if (en[i]) a[8*i +: 8] = b[8*i +: 8];
      end
      return a;
   endfunction

   function automatic logic [31:0] rd(input bit [30:0] key);
      return mem.exists(key) ? mem[key] : 32'h0;
   endfunction

   // everything happens at the rising memory clock
   always @(posedge mem_clk) begin
      // released lanes show the inverse of the last value, never a hold
      word = ~dq_out;
      k = {mode_sdram, hw_q, bank_q, row_q, addr};
      if (rd_wait > 0) begin
         rd_wait--;
         if (rd_wait == 0) word = merge(word, rd(rd_key), rd_lanes);
      end
      if (!mem_cke) begin
         word = word;
      end else if (!mode_sdram) begin
         if (sel_n[1:0] != 2'h3 && lane_n == 4'hf) begin
            row_q = addr;
            bank_q = !sel_n[1];
            hw_q = 1'b0;
         end else if (lane_n != 4'hf) begin
            if (!we_n) mem[k] = merge(rd(k), dq_in, ~lane_n);
            else word = merge(word, rd(k), ~lane_n);
         end
      end else if (sel_n != 4'hf) begin
         case ({ras_n, cas_n, we_n})
            esmp_pkg::CMD_ACTIVE: begin
               row_q = addr;
               bank_q = !sel_n[1] || !sel_n[3];
               hw_q = sel_n[3:2] != 2'h3;
            end
            esmp_pkg::CMD_READ: begin
               rd_key = k;
               rd_lanes = ~lane_n;
               rd_wait = `ESMP_CAS_LATENCY - 1;
            end
            esmp_pkg::CMD_WRITE: mem[k] = merge(rd(k), dq_in, ~lane_n);
            default: word = word;
         endcase
      end
      dq_out <= word;
   end
endmodule

// File: testbench/tb_top.sv
// self-checking bench for the edo / sdram memory port
`timescale 1ns/1ns

module tb_top;
   logic core_clk, rstn, mode, dimm, susp, req_valid, req_write, req_bank;
   logic req_hw, req_ready, rsp_valid, mem_clk, cke, ras_n, cas_n, we_n, oe;
   logic [13:0] req_row, mem_addr;
   logic [11:0] req_col;
   logic [3:0] req_be, lanes, sel_n, sel_seen, lane_seen;
   logic [31:0] req_wdata, rsp_rdata, dq_i, dq_o, dq_m;
   logic [31:0] seed = 32'h92b6;
   logic we_seen;
   logic mon_on = 1'b0;
   int bad_count = 0;
   int checks_done = 0;
   int unsigned exp_mem [bit [31:0]];

   // data bus wire: port drives on writes, memory otherwise
   assign dq_i = oe ? dq_o : dq_m;

   esmp_mem_port dut (.CORE_CLK(core_clk), .RSTN(rstn), .MODE_SDRAM(mode),
      .DIMM_FITTED(dimm), .CLK_SUSPEND(susp), .REQ_VALID(req_valid),
      .REQ_WRITE(req_write), .REQ_BANK(req_bank), .REQ_HIGH_WORD(req_hw),
      .REQ_ROW(req_row), .REQ_COL(req_col), .REQ_BYTE_EN(req_be),
      .REQ_WDATA(req_wdata), .REQ_READY(req_ready), .RSP_VALID(rsp_valid),
      .RSP_RDATA(rsp_rdata), .MEM_CLK(mem_clk), .MEM_CKE(cke),
      .BANK0_SELECT_LOW_N(sel_n[0]), .BANK1_SELECT_LOW_N(sel_n[1]),
      .BANK0_SELECT_HIGH_WORD_N(sel_n[2]), .BANK1_SELECT_HIGH_WORD_N(sel_n[3]),
      .ROW_STROBE_N(ras_n), .COL_STROBE_N(cas_n), .WRITE_STROBE_N(we_n),
      .BYTE_LANE_STROBE_MASK(lanes), .MEM_ADDR_MUX(mem_addr),
      .MEM_DATA_BUS_I(dq_i), .MEM_DATA_BUS_O(dq_o), .MEM_DATA_BUS_OE(oe));

   // on-board memory leaves the high-word selects unconnected
   esmp_tb_mem_model u_mem (.mem_clk(mem_clk), .mem_cke(cke),
      .mode_sdram(mode), .sel_n({dimm ? sel_n[3:2] : 2'h3, sel_n[1:0]}),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .lane_n(lanes),
      .addr(mem_addr), .dq_in(dq_i), .dq_out(dq_m));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // pins that were active at some point of the current access
   always @(negedge core_clk) begin
      if (mon_on) begin
         sel_seen |= ~sel_n;
         lane_seen |= ~lanes;
         we_seen |= ~we_n;
      end
   end

   task automatic do_op(input logic w, input logic [3:0] be,
      input logic [31:0] d, input logic hold);
      int n;
      bit [31:0] k;
      logic [31:0] e, m, got;
      got = 32'hx;
      n = 0;
      // inputs the caller set at this edge are only settled after it
      @(negedge core_clk);
      k = {mode, mode & dimm & req_hw, req_bank, req_row, req_col};
      e = exp_mem.exists(k) ? exp_mem[k] : 32'h0;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      if (hold) begin
         repeat (16) @(negedge core_clk);
         chk("clock enable idle", 32'h0, {31'h0, cke});
      end
      while (req_ready !== 1'b1 && n < 100) begin
         @(negedge core_clk);
         n++;
      end
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_be <= be;
      req_wdata <= d;
      sel_seen = 4'h0;
      lane_seen = 4'h0;
      we_seen = 1'b0;
      mon_on = 1'b1;
      @(posedge core_clk);
      req_valid <= 1'b0;
      n = 0;
      if (hold) begin
         // the access waits before its row phase until the clock runs
         while (cke !== 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
         end
         chk("clock enable run", 32'h1, {31'h0, cke});
         chk("select while held", 32'h0, {28'h0, sel_seen});
         @(posedge core_clk);
         susp <= 1'b0;
      end
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
         if (rsp_valid === 1'b1) got = rsp_rdata;
      end while (req_ready !== 1'b1 && n < 100);
      mon_on = 1'b0;
      chk("ready", 32'h1, {31'h0, req_ready});
      chk("select", 32'h1 << {k[27], k[26]},
         {28'h0, sel_seen});
      chk("lanes", {28'h0, be}, {28'h0, lane_seen});
      chk("write strobe", {31'h0, w}, {31'h0, we_seen});
      if (w) exp_mem[k] = (e & ~m) | (d & m);
      else chk("read data", e & m, got & m);
   endtask

   task automatic chk_reset;
      chk("idle pins", {19'h0, 4'hf, 3'h7, 4'hf, 2'h0},
         {19'h0, sel_n, ras_n, cas_n, we_n, lanes, cke, oe});
   endtask

   initial begin
      {rstn, mode, dimm, susp, req_valid, req_write, req_bank, req_hw} = 8'h0;
      req_row = 14'h0;
      req_col = 12'h0;
      req_be = 4'h0;
      req_wdata = 32'h0;
      repeat (20) @(posedge core_clk);
      chk_reset;
      rstn <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(posedge core_clk);
         seed = lfsr(seed);
         mode <= seed[0];
         dimm <= seed[1];
         req_hw <= seed[2];
         req_bank <= seed[3];
         req_row <= seed[0] ? seed[17:4] : {2'h0, seed[15:4]};
         req_col <= {1'b0, seed[28:18]};
         susp <= (i % 8 == 5);
         seed = lfsr(seed);
         do_op(1'b1, seed[3:0], lfsr(seed), i % 8 == 5);
         seed = lfsr(seed);
         do_op(1'b0, seed[3:0], 32'h0, 1'b0);
      end
      @(posedge core_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk_reset;
      finish_test;
   end

   // hang guard: each access takes well under 100 cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      finish_test;
   end
endmodule
